// ### core/step_seq_defs.svh
// Offsets, field positions, reset values and timing figures of the step sequencer.
// Assumes inclusion by bare name from files under core/.
`ifndef STEP_SEQ_DEFS_SVH
`define STEP_SEQ_DEFS_SVH

// ============================================================
// Timing
`define CLK_KHZ          125000
`define TIME_UNIT_MS     100
`define WIN_UNIT_MS      10
`define PULSE_MS         100

// ============================================================
// Register offsets (byte addresses)
`define OFS_CTRL         8'h00
`define OFS_WIN          8'h04
`define OFS_COUNT        8'h08
`define OFS_STATUS       8'h0C
`define OFS_FREQ         8'h10
`define OFS_TABLE        8'h40
`define OFS_TABLE_END    8'hC0

// ============================================================
// Field positions
`define CTRL_MODE_BIT    0
`define CTRL_RELAY_BIT   1
`define CTRL_DOUT_BIT    2
`define COUNT2_LSB       4
`define DIR_BIT          16
`define HOLD_LSB         16

// ============================================================
// Reset values and limits
`define WIN_RESET        8'h0A
`define WIN_MIN          8'h02
`define WIN_MAX          8'hC8
`define COUNT_RESET      4'h2
`define COUNT_MIN        4'h1
`define COUNT_MAX        4'h8
`define FREQ_RESET_FIRST 16'h044C
`define FREQ_RESET_OTHER 16'h0834
`define TIME_RESET       16'h0032
`define TIME_MIN         16'h0001
`define TIME_MAX         16'h1770
`define DIR_RESET        1'b1

`endif

// ### core/step_seq_pkg.sv
// Types shared by the step sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package step_seq_pkg;

	// ============================================================
	// Sequencer states and advance modes
	typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_CONFLICT, ST_RAMP, ST_HOLD, ST_WAIT} seq_state_e;
	typedef enum logic {ADV_AUTO, ADV_STEP} adv_mode_e;

	// ============================================================
	// One step of a sequence: times in 0.1 s units, frequency in 0.01 Hz
	typedef struct packed {
		logic [15:0] hold;
		logic [15:0] ramp;
		logic        dir;
		logic [15:0] freq;
	} step_cfg_s;

	// Register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_s;

endpackage

// ### core/step_table.sv
// Flip-flop store of the per-step settings, two words per step.
// Assumes writes come from the register port of the sequencer top.
`timescale 1ns/1ps
`include "step_seq_defs.svh"

module step_table #(
	parameter int ENTRIES = 16,
	parameter int IW      = $clog2(ENTRIES)
) (
	input  wire logic                   clk_sys_in,
	input  wire logic                   resetn_in,
	input  wire logic                   wr_in,
	input  wire logic [IW:0]            word_in,
	input  wire logic [31:0]            wdata_in,
	input  wire logic [IW-1:0]          look_idx_in,
	output step_seq_pkg::step_cfg_s     look_out,
	output logic      [31:0]            rdata_out
);
	import step_seq_pkg::*;

	step_cfg_s cfg [ENTRIES];

	// Keeps times inside 0.1 s .. 600.0 s
	function automatic logic [15:0] clamp_time(input logic [15:0] t);
		if (t < `TIME_MIN)
			return `TIME_MIN;
		if (t > `TIME_MAX)
			return `TIME_MAX;
		return t;
	endfunction

	// ============================================================
	// Storage, one entry per generate pass
	for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
		always_ff @(posedge clk_sys_in or negedge resetn_in) begin
			if (!resetn_in) begin
				cfg[i].freq <= ((i % 8) == 0) ? `FREQ_RESET_FIRST : `FREQ_RESET_OTHER;
				cfg[i].dir  <= `DIR_RESET;
				cfg[i].ramp <= `TIME_RESET;
				cfg[i].hold <= `TIME_RESET;
			end else if (wr_in && word_in[IW:1] == IW'(i)) begin
				if (!word_in[0]) begin
					cfg[i].freq <= wdata_in[15:0];
					cfg[i].dir  <= wdata_in[`DIR_BIT];
				end else begin
					cfg[i].ramp <= clamp_time(wdata_in[15:0]);
					cfg[i].hold <= clamp_time(wdata_in[`HOLD_LSB+:16]);
				end
			end
		end
	end

	// Lookup for the sequencer and for register reads
	assign look_out = cfg[look_idx_in];
	assign rdata_out = word_in[0] ? {cfg[word_in[IW:1]].hold, cfg[word_in[IW:1]].ramp}
	                              : {15'h0000, cfg[word_in[IW:1]].dir, cfg[word_in[IW:1]].freq};

endmodule

// ### core/pulse_stretch.sv
// Stretches a one-cycle trigger into a fixed-length output pulse.
// Assumes the trigger is synchronous to clk_sys_in.
`timescale 1ns/1ps

module pulse_stretch #(
	parameter int unsigned CYCLES = 12_500_000
) (
	input  wire logic clk_sys_in,
	input  wire logic resetn_in,
	input  wire logic trig_in,
	input  wire logic en_in,
	output logic      pulse_out
);
	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] left;

	// A new trigger restarts the full length
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			left      <= '0;
			pulse_out <= 1'b0;
		end else if (trig_in && en_in) begin
			left      <= W'(CYCLES - 1);
			pulse_out <= 1'b1;
		end else if (left != '0) begin
			left <= left - 1'b1;
		end else begin
			pulse_out <= 1'b0;
		end
	end

endmodule

// ### core/auto_step_sequencer.sv
// Two-sequence, eight-step frequency sequencer with step and end pulses.
// Assumes inputs synchronous to clk_sys_in and a register port with one-cycle strobes.
//
// Behaviour
// - In automatic mode the freeze input keeps the present step running without advancing.
// - With the relay set for step pulses it goes active for 100 ms at every step change.
// - With the digital output set for end pulses it goes active for 100 ms when the last step is reached.
// - In automatic mode a sequence input runs every step of that sequence in order unaided.
// - In stepwise mode, while the sequence input is held, each advance assertion moves one step.
// - Both sequence inputs count as simultaneous when the second comes within the window.
// - Each sequence runs only its configured number of steps, each with its own settings.
// - Step settings are indexed by sequence and step and give the step's frequency target.
// - Sequence two ramps from the present output frequency to its own first step's frequency target.
// - The step ramp time is how long the frequency takes to reach the step target.
// - After reaching the target the frequency holds for the step hold time before moving on.
// - Each step's direction setting drives the direction output while it runs.
// - Step counts are limited to one through eight and reset to two.
// - The simultaneity window is limited to 0.02 s through 2.00 s and resets to 0.10 s.
// - In stepwise mode the advance input acts only while the motor is stopped.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "step_seq_defs.svh"

module auto_step_sequencer #(
	parameter int unsigned TICK_CYCLES     = `TIME_UNIT_MS * `CLK_KHZ,
	parameter int unsigned WIN_UNIT_CYCLES = `WIN_UNIT_MS * `CLK_KHZ,
	parameter int unsigned PULSE_CYCLES    = `PULSE_MS * `CLK_KHZ
) (
	input  wire logic                   clk_sys_in,
	input  wire logic                   resetn_in,
	input  wire logic                   seq1_in,
	input  wire logic                   seq2_in,
	input  wire logic                   advance_in,
	input  wire logic                   hold_step_in,
	input  wire logic                   motor_stopped_in,
	input  step_seq_pkg::bus_req_s      bus_in,
	output logic      [31:0]            rdata_out,
	output logic      [15:0]            freq_ref_out,
	output logic                        dir_out,
	output logic                        run_out,
	output logic                        relay_out,
	output logic                        dout_out
);
	import step_seq_pkg::*;

	// ============================================================
	// Declarations
	adv_mode_e   advance_mode_parameter;
	logic        relay_step_fn;
	logic        digital_output_function;
	logic [7:0]  win_units;
	logic [3:0]  count1;
	logic [3:0]  count2;
	seq_state_e  state;
	logic        seq_sel;
	logic [2:0]  step_idx;
	logic [39:0] cnt;
	logic [15:0] start_freq;
	logic        conflict;
	logic        adv_d;
	step_cfg_s   cfg;
	logic [31:0] tbl_rdata;
	logic [4:0]  tbl_word;
	logic        tbl_hit;
	logic [3:0]  seq_count;
	logic [39:0] ramp_total;
	logic [39:0] hold_total;
	logic [39:0] win_total;
	logic        sel_held;
	logic        other_in;
	logic        freeze;
	logic        is_last;
	logic [2:0]  next_step_idx;
	logic        arb_done;
	logic        ramp_done;
	logic        hold_done;
	logic        adv_go;
	logic        go_next;
	logic        abort;
	logic        step_pulse;
	logic        end_pulse;
	logic        ramp_up;
	logic [15:0] ramp_mag;
	logic [55:0] ramp_prod;
	logic [55:0] ramp_quot;
	logic [15:0] ramp_freq;

	// ============================================================
	// Register port decode
	assign tbl_hit  = bus_in.addr >= `OFS_TABLE && bus_in.addr < `OFS_TABLE_END;
	assign tbl_word = 5'(bus_in.addr[7:2] - 6'h10);

	// Control register
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			advance_mode_parameter  <= ADV_AUTO;
			relay_step_fn           <= 1'b0;
			digital_output_function <= 1'b0;
		end else if (bus_in.wr && bus_in.addr == `OFS_CTRL) begin
			advance_mode_parameter  <= adv_mode_e'(bus_in.wdata[`CTRL_MODE_BIT]);
			relay_step_fn           <= bus_in.wdata[`CTRL_RELAY_BIT];
			digital_output_function <= bus_in.wdata[`CTRL_DOUT_BIT];
		end
	end

	// Window and step count registers, clamped into their legal ranges
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			win_units <= `WIN_RESET;
			count1    <= `COUNT_RESET;
			count2    <= `COUNT_RESET;
		end else if (bus_in.wr && bus_in.addr == `OFS_WIN) begin
			if (bus_in.wdata[7:0] > `WIN_MAX || bus_in.wdata[31:8] != 24'h0000_00)
				win_units <= `WIN_MAX;
			else if (bus_in.wdata[7:0] < `WIN_MIN)
				win_units <= `WIN_MIN;
			else
				win_units <= bus_in.wdata[7:0];
		end else if (bus_in.wr && bus_in.addr == `OFS_COUNT) begin
			count1 <= clamp_count(bus_in.wdata[3:0]);
			count2 <= clamp_count(bus_in.wdata[`COUNT2_LSB+:4]);
		end
	end

	function automatic logic [3:0] clamp_count(input logic [3:0] c);
		if (c < `COUNT_MIN)
			return `COUNT_MIN;
		if (c > `COUNT_MAX)
			return `COUNT_MAX;
		return c;
	endfunction

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in)
			rdata_out <= 32'h0000_0000;
		else if (!bus_in.rd)
			rdata_out <= 32'h0000_0000;
		else if (bus_in.addr == `OFS_CTRL)
			rdata_out <= {29'h0000_0000, digital_output_function, relay_step_fn, advance_mode_parameter};
		else if (bus_in.addr == `OFS_WIN)
			rdata_out <= {24'h0000_00, win_units};
		else if (bus_in.addr == `OFS_COUNT)
			rdata_out <= {24'h0000_00, count2, count1};
		else if (bus_in.addr == `OFS_STATUS)
			rdata_out <= {22'h00_0000, conflict, run_out, seq_sel, step_idx, 1'b0, state};
		else if (bus_in.addr == `OFS_FREQ)
			rdata_out <= {15'h0000, dir_out, freq_ref_out};
		else if (tbl_hit)
			rdata_out <= tbl_rdata;
		else
			rdata_out <= 32'h0000_0000;
	end

	// ============================================================
	// Step settings, addressed by sequence and step
	step_table #(.ENTRIES(16)) u_table (
		.clk_sys_in  (clk_sys_in),
		.resetn_in   (resetn_in),
		.wr_in       (bus_in.wr && tbl_hit),
		.word_in     (tbl_word),
		.wdata_in    (bus_in.wdata),
		.look_idx_in ({seq_sel, step_idx}),
		.look_out    (cfg),
		.rdata_out   (tbl_rdata)
	);

	// ============================================================
	// Sequencing conditions
	assign seq_count     = seq_sel ? count2 : count1;
	assign ramp_total    = 40'(cfg.ramp) * 40'(TICK_CYCLES);
	assign hold_total    = 40'(cfg.hold) * 40'(TICK_CYCLES);
	assign win_total     = 40'(win_units) * 40'(WIN_UNIT_CYCLES);
	assign sel_held      = seq_sel ? seq2_in : seq1_in;
	assign other_in      = seq_sel ? seq1_in : seq2_in;
	assign freeze        = advance_mode_parameter == ADV_AUTO && hold_step_in;
	assign is_last       = {1'b0, step_idx} == seq_count - 4'h1;
	assign next_step_idx = step_idx + 3'h1;
	assign arb_done      = state == ST_ARB && !other_in && sel_held && cnt >= win_total - 40'h1;
	assign ramp_done     = state == ST_RAMP && cnt >= ramp_total - 40'h1;
	assign hold_done     = state == ST_HOLD && !freeze && cnt >= hold_total - 40'h1;
	assign adv_go        = state == ST_WAIT && advance_in && !adv_d && motor_stopped_in;
	assign go_next       = (hold_done && !is_last && advance_mode_parameter == ADV_AUTO) || adv_go;
	assign abort         = advance_mode_parameter == ADV_STEP && !sel_held &&
	                       (state == ST_RAMP || state == ST_HOLD || state == ST_WAIT);
	assign step_pulse    = !abort && (arb_done || go_next);
	assign end_pulse     = !abort && ((arb_done && seq_count == `COUNT_MIN) ||
	                       (go_next && {1'b0, next_step_idx} == seq_count - 4'h1));

	// Linear ramp: start plus the elapsed share of the distance
	always_comb begin
		ramp_up   = cfg.freq >= start_freq;
		ramp_mag  = ramp_up ? cfg.freq - start_freq : start_freq - cfg.freq;
		ramp_prod = 56'(ramp_mag) * 56'(cnt + 40'h1);
		ramp_quot = ramp_prod / 56'(ramp_total);
		ramp_freq = ramp_up ? 16'(start_freq + ramp_quot[15:0]) : 16'(start_freq - ramp_quot[15:0]);
	end

	// Advance input edge detect
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in)
			adv_d <= 1'b0;
		else
			adv_d <= advance_in;
	end

	// ============================================================
	// Sequencer state machine
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state        <= ST_IDLE;
			seq_sel      <= 1'b0;
			step_idx     <= 3'h0;
			cnt          <= 40'h00_0000_0000;
			start_freq   <= 16'h0000;
			freq_ref_out <= 16'h0000;
			dir_out      <= `DIR_RESET;
			run_out      <= 1'b0;
			conflict     <= 1'b0;
		end else if (abort) begin
			state   <= ST_IDLE;
			run_out <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					cnt <= 40'h00_0000_0000;
					if (seq1_in && seq2_in) begin
						state    <= ST_CONFLICT;
						conflict <= 1'b1;
					end else if (seq1_in || seq2_in) begin
						state    <= ST_ARB;
						seq_sel  <= seq2_in;
						conflict <= 1'b0;
					end
				end
				ST_ARB: begin
					cnt <= cnt + 40'h1;
					if (other_in) begin
						state    <= ST_CONFLICT;
						conflict <= 1'b1;
					end else if (!sel_held) begin
						state <= ST_IDLE;
					end else if (arb_done) begin
						state      <= ST_RAMP;
						step_idx   <= 3'h0;
						start_freq <= freq_ref_out;
						cnt        <= 40'h00_0000_0000;
						run_out    <= 1'b1;
					end
				end
				ST_CONFLICT: begin
					if (!seq1_in && !seq2_in)
						state <= ST_IDLE;
				end
				ST_RAMP: begin
					dir_out      <= cfg.dir;
					freq_ref_out <= ramp_freq;
					if (ramp_done) begin
						state <= ST_HOLD;
						cnt   <= 40'h00_0000_0000;
					end else begin
						cnt <= cnt + 40'h1;
					end
				end
				ST_HOLD: begin
					dir_out <= cfg.dir;
					if (hold_done && is_last) begin
						state   <= ST_IDLE;
						run_out <= 1'b0;
					end else if (go_next) begin
						state      <= ST_RAMP;
						step_idx   <= next_step_idx;
						start_freq <= freq_ref_out;
						cnt        <= 40'h00_0000_0000;
					end else if (hold_done) begin
						state <= ST_WAIT;
					end else if (!freeze) begin
						cnt <= cnt + 40'h1;
					end
				end
				ST_WAIT: begin
					if (adv_go) begin
						state      <= ST_RAMP;
						step_idx   <= next_step_idx;
						start_freq <= freq_ref_out;
						cnt        <= 40'h00_0000_0000;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ============================================================
	// Output pulses, independent so that both may fire together
	pulse_stretch #(.CYCLES(PULSE_CYCLES)) u_step_pulse (
		.clk_sys_in (clk_sys_in),
		.resetn_in  (resetn_in),
		.trig_in    (step_pulse),
		.en_in      (relay_step_fn),
		.pulse_out  (relay_out)
	);

	pulse_stretch #(.CYCLES(PULSE_CYCLES)) u_end_pulse (
		.clk_sys_in (clk_sys_in),
		.resetn_in  (resetn_in),
		.trig_in    (end_pulse),
		.en_in      (digital_output_function),
		.pulse_out  (dout_out)
	);

	// ============================================================
	// Assertions
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	sequence last_ramp_s;
		state == ST_RAMP && ramp_done && !abort;
	endsequence

	sequence adv_req_s;
		state == ST_WAIT && advance_mode_parameter == ADV_STEP && sel_held && advance_in && !adv_d;
	endsequence

	hold_freeze_a: assert property (
		state == ST_HOLD && freeze && !abort |=> state == ST_HOLD && $stable(cnt) && $stable(step_idx))
		else $error("step advanced while frozen");

	step_relay_a: assert property (
		step_pulse && relay_step_fn |=> relay_out [*2])
		else $error("relay did not pulse on step change");

	end_dout_a: assert property (
		$rose(dout_out) |-> $past(end_pulse) && $past(digital_output_function))
		else $error("end pulse without last step");

	auto_advance_a: assert property (
		hold_done && !is_last && advance_mode_parameter == ADV_AUTO && !abort
		|=> state == ST_RAMP && step_idx == $past(next_step_idx))
		else $error("automatic advance missed");

	one_step_a: assert property (
		adv_req_s ##0 motor_stopped_in |=> state == ST_RAMP && step_idx == $past(step_idx) + 3'h1)
		else $error("stepwise advance wrong");

	stopped_only_a: assert property (
		state == ST_WAIT && !motor_stopped_in && !abort |=> $stable(step_idx))
		else $error("advance taken while motor runs");

	window_conflict_a: assert property (
		state == ST_ARB && other_in && !abort |=> state == ST_CONFLICT && conflict)
		else $error("simultaneous inputs not detected");

	step_limit_a: assert property (
		run_out |-> {1'b0, step_idx} < seq_count && seq_count >= `COUNT_MIN && seq_count <= `COUNT_MAX)
		else $error("step beyond count");

	ramp_land_a: assert property (
		last_ramp_s |=> freq_ref_out == $past(cfg.freq) && state == ST_HOLD)
		else $error("ramp did not land on target");

	dir_apply_a: assert property (
		state == ST_HOLD ##1 state == ST_HOLD |-> dir_out == $past(cfg.dir))
		else $error("direction not applied");

	both_pulses_a: assert property (
		step_pulse && end_pulse && relay_step_fn && digital_output_function |=> relay_out && dout_out)
		else $error("coincident pulse suppressed");

endmodule

// ### testbench/drive_stage_model.sv
// Drive output stage model: reports the motor stopped a while after a stop request.
// Assumes the clock and reset of the sequencer bench.
`timescale 1ns/1ps

module drive_stage_model #(
	parameter int DELAY = 5
) (
	input  wire logic clk_sys_in,
	input  wire logic resetn_in,
	input  wire logic stop_req_in,
	output logic      motor_stopped_out
);
	logic [7:0] coast;

	// ============================================================
	// Coasting: stopped only once the request has stood DELAY cycles
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			coast <= 8'h00;
		end else if (!stop_req_in) begin
			coast <= 8'h00;
		end else if (coast < 8'(DELAY)) begin
			coast <= coast + 8'h01;
		end
	end

	// Drops at once when the request goes away
	assign motor_stopped_out = stop_req_in && (coast == 8'(DELAY));
endmodule

// ### testbench/auto_step_sequencer_tb.sv
// Self-checking bench of the step sequencer with shortened tick, window and pulse counts.
// Assumes the design files under core/ and the drive stage model.
`timescale 1ns/1ps

module auto_step_sequencer_tb;
	import step_seq_pkg::*;

	logic        clk_sys_in = 1'b0;
	logic        resetn_in  = 1'b0;
	logic        seq1       = 1'b0;
	logic        seq2       = 1'b0;
	logic        adv        = 1'b0;
	logic        hold       = 1'b0;
	logic        stop_req   = 1'b0;
	logic        stopped;
	bus_req_s    bus        = '0;
	logic [31:0] rdata;
	logic [15:0] freq;
	logic        dir;
	logic        run;
	logic        relay;
	logic        dout;
	logic        rd_q       = 1'b0;
	logic [31:0] rng        = 32'h0000_0022;
	logic [31:0] q[$];
	logic [15:0] f[8];
	logic        d[8];
	logic [15:0] rt[8];
	int          fail_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          run_cyc = 0;
	int          rel_n = 0;
	int          end_n = 0;
	int          w_r = 0;
	int          w_d = 0;

	// Clock of 8 ns
	always #4 clk_sys_in = ~clk_sys_in;

	auto_step_sequencer #(.TICK_CYCLES(4), .WIN_UNIT_CYCLES(2), .PULSE_CYCLES(6)) i_dut (
		.clk_sys_in       (clk_sys_in),
		.resetn_in        (resetn_in),
		.seq1_in          (seq1),
		.seq2_in          (seq2),
		.advance_in       (adv),
		.hold_step_in     (hold),
		.motor_stopped_in (stopped),
		.bus_in           (bus),
		.rdata_out        (rdata),
		.freq_ref_out     (freq),
		.dir_out          (dir),
		.run_out          (run),
		.relay_out        (relay),
		.dout_out         (dout)
	);

	drive_stage_model i_drive (
		.clk_sys_in        (clk_sys_in),
		.resetn_in         (resetn_in),
		.stop_req_in       (stop_req),
		.motor_stopped_out (stopped)
	);

	// ============================================================
	// Helpers
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	task automatic give_verdict();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// One bus cycle with a one-cycle strobe
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] dt);
		@(posedge clk_sys_in);
		bus <= '{a, dt, w, r};
		@(posedge clk_sys_in);
		bus <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		op(1'b0, 1'b1, a, 32'h0000_0000);
	endtask

	task automatic wait_run(input logic v);
		for (int i = 0; i < 100 && run !== v; i++) @(negedge clk_sys_in);
		check(run, v);
	endtask

	task automatic pulse_adv();
		@(posedge clk_sys_in);
		adv <= 1'b1;
		@(posedge clk_sys_in);
		adv <= 1'b0;
	endtask

	// Random step settings for one sequence
	task automatic prog(input int s, input int n);
		logic [7:0] a;
		for (int i = 0; i < n; i++) begin
			f[i] = 16'(xs());
			d[i] = 1'(xs());
			rt[i] = 16'(xs() % 2 + 1);
			a = 8'(64 + 8 * (s * 8 + i));
			op(1'b1, 1'b0, a, {15'h0000, d[i], f[i]});
			op(1'b1, 1'b0, a + 8'h04, {16'h0002, rt[i]});
		end
		rd(8'(64 + 64 * s), {15'h0000, d[0], f[0]});
		rel_n = 0;
		end_n = 0;
		run_cyc = 0;
	endtask

	// Automatic run, optional freeze of fz cycles in the first hold
	task automatic run_auto(input int s, input int n, input int fz);
		int tot;
		tot = fz;
		op(1'b1, 1'b0, 8'h08, {24'h00_0000, 4'(n), 4'(n)});
		prog(s, n);
		@(posedge clk_sys_in);
		if (s == 1) seq2 <= 1'b1;
		else seq1 <= 1'b1;
		wait_run(1'b1);
		for (int i = 0; i < n; i++) begin
			repeat (rt[i] * 4 + 3) @(negedge clk_sys_in);
			check(freq, f[i]);
			check(dir, d[i]);
			@(posedge clk_sys_in);
			seq1 <= 1'b0;
			seq2 <= 1'b0;
			if (i == 0 && fz > 0) begin
				hold <= 1'b1;
				repeat (fz) @(posedge clk_sys_in);
				hold <= 1'b0;
			end
			repeat (5) @(negedge clk_sys_in);
			tot += rt[i] * 4 + 8;
		end
		wait_run(1'b0);
		check(run_cyc, tot);
		rd(8'h10, {15'h0000, d[n-1], f[n-1]});
		repeat (8) @(negedge clk_sys_in);
		check(rel_n, n);
		check(end_n, 1);
	endtask

	// ============================================================
	// Read data watcher: one note per read
	always @(posedge clk_sys_in) begin
		if (rd_q) check(rdata, q.pop_front());
		rd_q <= bus.rd;
	end

	// Pulse widths, run length and hang guard
	always @(negedge clk_sys_in) begin
		if (run) run_cyc++;
		if (relay) w_r++;
		else if (w_r != 0) begin
			check(w_r, 6);
			rel_n++;
			w_r = 0;
		end
		if (dout) w_d++;
		else if (w_d != 0) begin
			check(w_d, 6);
			end_n++;
			w_d = 0;
		end
		cyc++;
		if (cyc > 20000) begin
			fail_count++;
			give_verdict();
		end
	end

	// ============================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		@(negedge clk_sys_in);
		check({freq, dir, run, relay, dout}, 32'h0000_0008);
		rd(8'h08, 32'h0000_0022);
		rd(8'h04, 32'h0000_000A);
		rd(8'h40, 32'h0001_044C);
		rd(8'h48, 32'h0001_0834);
		rd(8'h80, 32'h0001_044C);
		rd(8'h44, 32'h0032_0032);
		rd(8'h20, 32'h0000_0000);
		op(1'b1, 1'b0, 8'h08, 32'h0000_000F);
		rd(8'h08, 32'h0000_0018);
		op(1'b1, 1'b0, 8'h04, 32'h0000_0001);
		rd(8'h04, 32'h0000_0002);
		op(1'b1, 1'b0, 8'h04, 32'h0000_0300);
		rd(8'h04, 32'h0000_00C8);
		op(1'b1, 1'b0, 8'h04, 32'h0000_0002);
		op(1'b1, 1'b0, 8'h00, 32'h0000_0006);
		run_auto(0, 2, 0);
		run_auto(0, 8, 10);
		run_auto(1, 1, 0);
		// Both inputs together, then the second inside the window
		run_cyc = 0;
		@(posedge clk_sys_in);
		seq1 <= 1'b1;
		seq2 <= 1'b1;
		rd(8'h0C, 32'h0000_0282);
		repeat (18) @(posedge clk_sys_in);
		seq1 <= 1'b0;
		seq2 <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		seq1 <= 1'b1;
		@(posedge clk_sys_in);
		seq2 <= 1'b1;
		repeat (20) @(posedge clk_sys_in);
		seq1 <= 1'b0;
		seq2 <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		check(run_cyc, 0);
		// Stepwise advance, refused while the motor turns
		op(1'b1, 1'b0, 8'h00, 32'h0000_0007);
		op(1'b1, 1'b0, 8'h08, 32'h0000_0022);
		prog(0, 2);
		@(posedge clk_sys_in);
		seq1 <= 1'b1;
		wait_run(1'b1);
		repeat (rt[0] * 4 + 3) @(negedge clk_sys_in);
		check(freq, f[0]);
		repeat (12) @(negedge clk_sys_in);
		pulse_adv();
		repeat (8) @(negedge clk_sys_in);
		check(freq, f[0]);
		@(posedge clk_sys_in);
		stop_req <= 1'b1;
		repeat (8) @(posedge clk_sys_in);
		pulse_adv();
		repeat (rt[1] * 4 + 3) @(negedge clk_sys_in);
		check(freq, f[1]);
		@(posedge clk_sys_in);
		seq1 <= 1'b0;
		stop_req <= 1'b0;
		repeat (3) @(negedge clk_sys_in);
		check(run, 1'b0);
		repeat (8) @(negedge clk_sys_in);
		check(rel_n, 2);
		give_verdict();
	end
endmodule
